// *** hdl/hism_cfg.svh ***
// Address map, bit positions and reset values of the interrupt service map
`ifndef HISM_CFG_SVH
`define HISM_CFG_SVH
// ------------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------------
`define HISM_ADDR_BLK_STAT_1     16'h0112
`define HISM_ADDR_BLK_STAT_0     16'h0113
`define HISM_ADDR_BLK_EN_1       16'h0116
`define HISM_ADDR_BLK_EN_0       16'h0117
`define HISM_ADDR_OP_SRC_STAT    16'h010b
`define HISM_ADDR_IND_RX_PATH    16'h0120
`define HISM_ADDR_IND_FRAMER     16'h0122
`define HISM_ADDR_IND_MAPPER     16'h0126
`define HISM_ADDR_IND_TX_CELL    16'h0127
`define HISM_ADDR_IND_RX_CELL    16'h0128
`define HISM_ADDR_IND_RX_PACKET  16'h012a
`define HISM_ADDR_IND_TX_PACKET  16'h012c
`define HISM_ADDR_TRN_STAT_2     16'h1109
`define HISM_ADDR_TRN_STAT_1     16'h110a
`define HISM_ADDR_TRN_STAT_0     16'h110b
// ------------------------------------------------------------------
// Block-level bit positions (byte 1 then byte 0 as one 16-bit word)
// ------------------------------------------------------------------
`define HISM_BIT_OP_CTRL    15
`define HISM_BIT_MAPPER     14
`define HISM_BIT_FRAMER     10
`define HISM_BIT_RX_CELL    7
`define HISM_BIT_RX_TOH     6
`define HISM_BIT_RX_PATH    5
`define HISM_BIT_RX_PACKET  4
`define HISM_BIT_TX_CELL    3
`define HISM_BIT_TX_PACKET  0
`define HISM_BLK_USED_MASK  16'hc4f9
// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define HISM_RST_BYTE       8'h00
`define HISM_RST_WORD       16'h0000
`define HISM_RST_IRQ_N      1'b1
`endif

// *** hdl/hism_pkg.sv ***
// Types shared by the interrupt service map
`default_nettype none
package hism_pkg;
    // Host access strobe group
    typedef struct packed {
        logic        rd;     // Read strobe, one cycle
        logic        wr;     // Write strobe, one cycle
        logic [15:0] addr;   // Byte address
        logic [7:0]  wdata;  // Write data
    } hism_req_t;
    // Source events, one-cycle pulses per bit
    typedef struct packed {
        logic [7:0] op_ctrl;  // Operation control sources
        logic [7:0] trn_2;    // Receive transport byte 2 sources
        logic [7:0] trn_1;    // Receive transport byte 1 sources
        logic [7:0] trn_0;    // Receive transport byte 0 sources
    } hism_evt_t;
    // Per-channel request levels of the seven channelized blocks
    typedef struct packed {
        logic [2:0] rx_cell;
        logic [2:0] rx_path;
        logic [2:0] rx_packet;
        logic [2:0] tx_cell;
        logic [2:0] tx_packet;
        logic [2:0] mapper;
        logic [2:0] framer;
    } hism_chan_t;
endpackage
`default_nettype wire

// *** hdl/hism_irq_map.sv ***
// Hierarchical interrupt service map: block status, enables, indicators, clear-on-read sources
//
// Operation
// - Block-level status reports nine functional blocks
// - Operation source status held at 0x010B
// - Receive cell, path, packet indicators provided
// - Transmit cell, mapper, framer indicators provided
// - Three transport status bytes, descending addresses
// - Transmit packet block has channel indicator
// - Reading operation source status clears it
// - Reading transport status clears read byte
// - Block bit clears once sources cleared
// - Request output released when nothing pending
// - Indicator identifies exactly the requesting channel
// - Zero enable bit blocks that block's requests
// - Indicator bit one while channel requesting
`timescale 1ns/1ps
`default_nettype none
`include "hism_cfg.svh"
module hism_irq_map (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire hism_pkg::hism_req_t  host_req,
    input  wire hism_pkg::hism_evt_t  src_evt,
    input  wire hism_pkg::hism_chan_t chan_req,
    output var  logic [7:0]           host_rdata,
    output var  logic                 host_rvalid,
    output var  logic                 irq_n
);
    import hism_pkg::*;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire logic rd_op    = host_req.rd && (host_req.addr == `HISM_ADDR_OP_SRC_STAT);
    wire logic rd_trn2  = host_req.rd && (host_req.addr == `HISM_ADDR_TRN_STAT_2);
    wire logic rd_trn1  = host_req.rd && (host_req.addr == `HISM_ADDR_TRN_STAT_1);
    wire logic rd_trn0  = host_req.rd && (host_req.addr == `HISM_ADDR_TRN_STAT_0);
    wire logic wr_en1   = host_req.wr && (host_req.addr == `HISM_ADDR_BLK_EN_1);
    wire logic wr_en0   = host_req.wr && (host_req.addr == `HISM_ADDR_BLK_EN_0);

    // Only implemented block bits take a write; the others read back zero
    wire logic [15:0] en_mask  = `HISM_BLK_USED_MASK;            // Writable enable bits
    wire logic [7:0]  en_wr_hi = host_req.wdata & en_mask[15:8];
    wire logic [7:0]  en_wr_lo = host_req.wdata & en_mask[7:0];

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [15:0] blk_en_q;        // Block enables, bytes 1:0
    logic [7:0]  op_stat_q;       // Operation source status, clear on read
    logic [7:0]  trn_q [3];       // Transport status bytes 0..2, clear on read
    logic [7:0]  trn_d [3];       // Next transport status
    logic [7:0]  op_stat_d;       // Next operation status
    logic [7:0]  trn_evt [3];     // Transport events by byte index
    logic        trn_rd [3];      // Transport read strobes by byte index

    assign trn_evt[0] = src_evt.trn_0;
    assign trn_evt[1] = src_evt.trn_1;
    assign trn_evt[2] = src_evt.trn_2;
    assign trn_rd[0]  = rd_trn0;
    assign trn_rd[1]  = rd_trn1;
    assign trn_rd[2]  = rd_trn2;

    // Clear on read, but a new event in the read cycle survives the clear
    assign op_stat_d = (rd_op ? `HISM_RST_BYTE : op_stat_q) | src_evt.op_ctrl;

    // ------------------------------------------------------------------
    // Transport status bytes, one per generate entry
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_trn
            assign trn_d[gi] = (trn_rd[gi] ? `HISM_RST_BYTE : trn_q[gi]) | trn_evt[gi];
            // Byte register, cleared by its own read only
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    trn_q[gi] <= `HISM_RST_BYTE;
                end else begin
                    trn_q[gi] <= trn_d[gi];
                end
            end
        end
    endgenerate

    // Source status and enables
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            op_stat_q <= `HISM_RST_BYTE;
            blk_en_q  <= `HISM_RST_WORD;
        end else begin
            op_stat_q <= op_stat_d;
            if (wr_en1) begin
                // Byte 1 write, masked to implemented bits
                blk_en_q[15:8] <= en_wr_hi;
            end
            if (wr_en0) begin
                // Byte 0 write, masked to implemented bits
                blk_en_q[7:0] <= en_wr_lo;
            end
        end
    end

    // ------------------------------------------------------------------
    // Block-level status, derived live from the sources below it
    // ------------------------------------------------------------------
    // Deriving it rather than latching it means a block bit falls in the
    // same cycle that its last source register clears, with no extra handshake.
    logic [15:0] blk_stat;  // Raw block-level requests
    always_comb begin
        blk_stat = `HISM_RST_WORD;
        blk_stat[`HISM_BIT_OP_CTRL]   = |op_stat_q;
        blk_stat[`HISM_BIT_RX_TOH]    = |trn_q[0] | |trn_q[1] | |trn_q[2];
        blk_stat[`HISM_BIT_MAPPER]    = |chan_req.mapper;
        blk_stat[`HISM_BIT_FRAMER]    = |chan_req.framer;
        blk_stat[`HISM_BIT_RX_CELL]   = |chan_req.rx_cell;
        blk_stat[`HISM_BIT_RX_PATH]   = |chan_req.rx_path;
        blk_stat[`HISM_BIT_RX_PACKET] = |chan_req.rx_packet;
        blk_stat[`HISM_BIT_TX_CELL]   = |chan_req.tx_cell;
        blk_stat[`HISM_BIT_TX_PACKET] = |chan_req.tx_packet;
    end

    // Status gated by enables; disabled blocks cannot request
    wire logic [15:0] blk_gated = blk_stat & blk_en_q;
    wire logic        irq_d_n   = ~|blk_gated;

    // Request output, released when nothing enabled is pending
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_n <= `HISM_RST_IRQ_N;
        end else begin
            irq_n <= irq_d_n;
        end
    end

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    logic [7:0] rd_mux;  // Selected read value
    always_comb begin
        case (host_req.addr)
            `HISM_ADDR_BLK_STAT_1:    rd_mux = blk_gated[15:8];
            `HISM_ADDR_BLK_STAT_0:    rd_mux = blk_gated[7:0];
            `HISM_ADDR_BLK_EN_1:      rd_mux = blk_en_q[15:8];
            `HISM_ADDR_BLK_EN_0:      rd_mux = blk_en_q[7:0];
            `HISM_ADDR_OP_SRC_STAT:   rd_mux = op_stat_q;
            `HISM_ADDR_IND_RX_CELL:   rd_mux = {5'h0, chan_req.rx_cell};
            `HISM_ADDR_IND_RX_PATH:   rd_mux = {5'h0, chan_req.rx_path};
            `HISM_ADDR_IND_RX_PACKET: rd_mux = {5'h0, chan_req.rx_packet};
            `HISM_ADDR_IND_TX_CELL:   rd_mux = {5'h0, chan_req.tx_cell};
            `HISM_ADDR_IND_MAPPER:    rd_mux = {5'h0, chan_req.mapper};
            `HISM_ADDR_IND_FRAMER:    rd_mux = {5'h0, chan_req.framer};
            `HISM_ADDR_IND_TX_PACKET: rd_mux = {5'h0, chan_req.tx_packet};
            `HISM_ADDR_TRN_STAT_2:    rd_mux = trn_q[2];
            `HISM_ADDR_TRN_STAT_1:    rd_mux = trn_q[1];
            `HISM_ADDR_TRN_STAT_0:    rd_mux = trn_q[0];
            default:                  rd_mux = `HISM_RST_BYTE;            // Unmapped reads zero
        endcase
    end

    // Read data registered; shows pre-clear contents of clear-on-read bytes
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            host_rdata  <= `HISM_RST_BYTE;
            host_rvalid <= 1'b0;
        end else begin
            host_rdata  <= host_req.rd ? rd_mux : host_rdata;
            host_rvalid <= host_req.rd;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_OP_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_op && src_evt.op_ctrl == 8'h00 |=> op_stat_q == 8'h00)
        else $error("operation status not cleared by read");
    AST_OP_SETWIN: assert property (@(posedge sys_clk) disable iff (!rst_n)
        src_evt.op_ctrl != 8'h00 |=> (op_stat_q & $past(src_evt.op_ctrl)) == $past(src_evt.op_ctrl))
        else $error("operation event lost");
    AST_TRN_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_trn1 && src_evt.trn_1 == 8'h00 |=> trn_q[1] == 8'h00)
        else $error("transport byte not cleared by read");
    AST_TRN_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !rd_trn2 |=> (trn_q[2] & $past(trn_q[2])) == $past(trn_q[2]))
        else $error("transport byte lost bits without read");
    AST_EN_GATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        blk_en_q == 16'h0000 |=> irq_n)
        else $error("disabled blocks raised request");
    AST_IRQ_ASSERT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (blk_stat & blk_en_q) != 16'h0000 |=> !irq_n)
        else $error("request not asserted");
    AST_RELEASE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_op && blk_en_q[`HISM_BIT_OP_CTRL] && src_evt.op_ctrl == 8'h00
        && (blk_stat & blk_en_q) == 16'h8000 |=> ##1 irq_n)
        else $error("request not released after clear");
    AST_IND_READ: assert property (@(posedge sys_clk) disable iff (!rst_n)
        host_req.rd && host_req.addr == `HISM_ADDR_IND_MAPPER
        |=> host_rvalid && host_rdata == {5'h0, $past(chan_req.mapper)})
        else $error("indicator read mismatch");
    AST_BLK_TOH: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (trn_q[0] | trn_q[1] | trn_q[2]) == 8'h00 |-> !blk_stat[`HISM_BIT_RX_TOH])
        else $error("block bit stuck after sources cleared");

    // ------------------------------------------------------------------
    // Checks: clear-on-read sources
    // ------------------------------------------------------------------
    // Unread operation status keeps every bit it holds
    AST_OP_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !rd_op |=> (op_stat_q & $past(op_stat_q)) == $past(op_stat_q))
        else $error("operation status lost bits without read");

    // Block bit falls with its cleared operation sources
    AST_BLK_OP_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_op && src_evt.op_ctrl == 8'h00 |=> !blk_stat[`HISM_BIT_OP_CTRL])
        else $error("operation block bit stuck after read");

    // Transport byte 0 clears on its own read
    AST_TRN0_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_trn0 && src_evt.trn_0 == 8'h00 |=> trn_q[0] == 8'h00)
        else $error("transport byte 0 not cleared by read");

    // Transport byte 2 clears on its own read
    AST_TRN2_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_trn2 && src_evt.trn_2 == 8'h00 |=> trn_q[2] == 8'h00)
        else $error("transport byte 2 not cleared by read");

    // A transport event in a read cycle survives the clear
    AST_TRN_SETWIN: assert property (@(posedge sys_clk) disable iff (!rst_n)
        src_evt.trn_1 != 8'h00 |=> (trn_q[1] & $past(src_evt.trn_1)) == $past(src_evt.trn_1))
        else $error("transport event lost");

    // Any transport event raises the transport block bit next cycle
    AST_TOH_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (src_evt.trn_0 | src_evt.trn_1 | src_evt.trn_2) != 8'h00 |=> blk_stat[`HISM_BIT_RX_TOH])
        else $error("transport block bit not raised");

    // ------------------------------------------------------------------
    // Checks: enables and request output
    // ------------------------------------------------------------------
    // Unimplemented enable bits never hold a one
    AST_EN_MASK: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (blk_en_q & ~`HISM_BLK_USED_MASK) == 16'h0000)
        else $error("unimplemented enable bit set");

    // Byte 0 write keeps only implemented bits
    AST_EN_WRITE_LO: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_en0 |=> blk_en_q[7:0] == ($past(host_req.wdata) & 8'(`HISM_BLK_USED_MASK)))
        else $error("enable byte 0 write mismatch");

    // Byte 1 write keeps only implemented bits
    AST_EN_WRITE_HI: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_en1 |=> blk_en_q[15:8] == ($past(host_req.wdata) & 8'(`HISM_BLK_USED_MASK >> 8)))
        else $error("enable byte 1 write mismatch");

    // Enables change only on their own writes
    AST_EN_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !wr_en1 && !wr_en0 |=> $stable(blk_en_q))
        else $error("enables changed without write");

    // An enabled channelized block alone pulls the request low
    AST_IRQ_MAPPER: assert property (@(posedge sys_clk) disable iff (!rst_n)
        blk_en_q[`HISM_BIT_MAPPER] && chan_req.mapper != 3'h0 |=> !irq_n)
        else $error("mapper request not raised");

    // Nothing enabled pending means the request is released
    AST_IRQ_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (blk_stat & blk_en_q) == 16'h0000 |=> irq_n)
        else $error("request held with nothing pending");

    // ------------------------------------------------------------------
    // Checks: read path
    // ------------------------------------------------------------------
    // Every read is answered exactly one cycle later
    AST_RVALID: assert property (@(posedge sys_clk) disable iff (!rst_n)
        host_req.rd |=> host_rvalid)
        else $error("read not answered");

    // No answer without a read
    AST_RVALID_ONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !host_req.rd |=> !host_rvalid)
        else $error("answer without read");

    // Read data holds between reads
    AST_RDATA_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !host_req.rd |=> $stable(host_rdata))
        else $error("read data changed without read");

    // Receive cell indicator names the requesting channels
    AST_IND_RXCELL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        host_req.rd && host_req.addr == `HISM_ADDR_IND_RX_CELL
        |=> host_rdata == {5'h0, $past(chan_req.rx_cell)})
        else $error("receive cell indicator mismatch");

    // Framer indicator names the requesting channels
    AST_IND_FRAMER: assert property (@(posedge sys_clk) disable iff (!rst_n)
        host_req.rd && host_req.addr == `HISM_ADDR_IND_FRAMER
        |=> host_rdata == {5'h0, $past(chan_req.framer)})
        else $error("framer indicator mismatch");

    // Transmit packet indicator names the requesting channels
    AST_IND_TXPKT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        host_req.rd && host_req.addr == `HISM_ADDR_IND_TX_PACKET
        |=> host_rdata == {5'h0, $past(chan_req.tx_packet)})
        else $error("transmit packet indicator mismatch");
endmodule
`default_nettype wire

// *** tb/hism_host_model.sv ***
// Host processor model: drives register reads and writes of the interrupt service map
`timescale 1ns/1ps
`default_nettype none
module hism_host_model (
    input  wire logic                sys_clk,     // System clock
    input  wire logic                host_rvalid, // Read answer strobe
    input  wire logic [7:0]          host_rdata,  // Read answer data
    output var  hism_pkg::hism_req_t host_req     // Access strobes, address, data
);
    import hism_pkg::*;
    // ------------------------------------------------------------------
    // Bus access tasks
    // ------------------------------------------------------------------
    // Idle bus at time zero
    initial host_req = '0;
    // One-cycle write; address and data inverted after release so stale values never look valid
    task automatic write(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        host_req.wr    <= 1'b1;
        host_req.addr  <= a;
        host_req.wdata <= d;
        @(posedge sys_clk);
        host_req.wr    <= 1'b0;
        host_req.addr  <= ~a;
        host_req.wdata <= ~d;
    endtask
    // One-cycle read; answer is taken just after the edge that drops the strobe, bounded wait
    task automatic read(input logic [15:0] a, output logic [7:0] d, output logic ok);
        int i;
        ok = 1'b0;
        d  = 8'h00;
        @(posedge sys_clk);
        host_req.rd   <= 1'b1;
        host_req.addr <= a;
        @(posedge sys_clk);
        host_req.rd   <= 1'b0;
        host_req.addr <= ~a;
        for (i = 0; i < 4 && !ok; i++) begin
            #1;
            if (host_rvalid === 1'b1) begin
                d  = host_rdata;
                ok = 1'b1;
            end else begin
                @(posedge sys_clk);
            end
        end
    endtask
endmodule
`default_nettype wire

// *** tb/hism_irq_map_test.sv ***
// Self-checking testbench of the interrupt service map
`timescale 1ns/1ps
`default_nettype none
`include "hism_cfg.svh"
module hism_irq_map_test;
    import hism_pkg::*;
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic        sys_clk, rst_n, host_rvalid, irq_n, rd_ok;
    hism_req_t   host_req;
    hism_evt_t   src_evt;
    hism_chan_t  chan_req;
    logic [7:0]  host_rdata, rd_val;
    logic [15:0] exp16;
    int          errors, n_checks;
    // Indicator addresses and block bits of the seven channelized blocks, in struct order
    logic [15:0] ind_addr [7] = '{`HISM_ADDR_IND_RX_CELL, `HISM_ADDR_IND_RX_PATH, `HISM_ADDR_IND_RX_PACKET,
        `HISM_ADDR_IND_TX_CELL, `HISM_ADDR_IND_TX_PACKET, `HISM_ADDR_IND_MAPPER, `HISM_ADDR_IND_FRAMER};
    int          blk_bit [7] = '{`HISM_BIT_RX_CELL, `HISM_BIT_RX_PATH, `HISM_BIT_RX_PACKET, `HISM_BIT_TX_CELL,
        `HISM_BIT_TX_PACKET, `HISM_BIT_MAPPER, `HISM_BIT_FRAMER};
    hism_irq_map hism_irq_map_inst (.sys_clk(sys_clk), .rst_n(rst_n), .host_req(host_req), .src_evt(src_evt),
        .chan_req(chan_req), .host_rdata(host_rdata), .host_rvalid(host_rvalid), .irq_n(irq_n));
    hism_host_model hism_host_model_inst (.sys_clk(sys_clk), .host_rvalid(host_rvalid),
        .host_rdata(host_rdata), .host_req(host_req));
    // 200 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------------------------
    // Helper tasks
    // ------------------------------------------------------------------
    // Compare and count; case inequality so an unknown never matches
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Single exit point of the run
    task automatic report_and_stop;
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Read through the host model and compare; a missing answer ends the run
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        hism_host_model_inst.read(a, rd_val, rd_ok);
        check({8'h00, rd_val}, {8'h00, exp});
        if (rd_ok !== 1'b1) begin
            errors++;
            report_and_stop;
        end
    endtask
    // One-cycle source event pulse
    task automatic pulse(input hism_evt_t e);
        @(posedge sys_clk);
        src_evt <= e;
        @(posedge sys_clk);
        src_evt <= '0;
    endtask
    // Let registered status and request output land
    task automatic settle;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    // Hang guard
    initial begin
        #100000;
        errors++;
        report_and_stop;
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        src_evt = '0;
        chan_req = '0;
        errors = 0;
        n_checks = 0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        settle;
        check({15'h0, irq_n}, 16'h0001);
        rd_chk(`HISM_ADDR_BLK_EN_1, 8'h00);
        rd_chk(`HISM_ADDR_BLK_EN_0, 8'h00);
        // Source pending while its block is disabled: no request, status masked
        pulse(hism_evt_t'(32'h05000000));
        settle;
        check({15'h0, irq_n}, 16'h0001);
        rd_chk(`HISM_ADDR_BLK_STAT_1, 8'h00);
        // Enable all; only implemented block bits take the write
        hism_host_model_inst.write(`HISM_ADDR_BLK_EN_1, 8'hff);
        hism_host_model_inst.write(`HISM_ADDR_BLK_EN_0, 8'hff);
        rd_chk(`HISM_ADDR_BLK_EN_1, 8'hc4);
        rd_chk(`HISM_ADDR_BLK_EN_0, 8'hf9);
        settle;
        check({15'h0, irq_n}, 16'h0000);
        // Service routine branches on block status, then reads the source register twice
        rd_chk(`HISM_ADDR_BLK_STAT_1, 8'h80);
        rd_chk(`HISM_ADDR_OP_SRC_STAT, 8'h05);
        rd_chk(`HISM_ADDR_OP_SRC_STAT, 8'h00);
        settle;
        check({15'h0, irq_n}, 16'h0001);
        rd_chk(`HISM_ADDR_BLK_STAT_1, 8'h00);
        // Transport overhead sources in all three bytes
        pulse(hism_evt_t'(32'h00018010));
        settle;
        check({15'h0, irq_n}, 16'h0000);
        rd_chk(`HISM_ADDR_BLK_STAT_0, 8'h40);
        rd_chk(`HISM_ADDR_TRN_STAT_2, 8'h01);
        rd_chk(`HISM_ADDR_TRN_STAT_1, 8'h80);
        rd_chk(`HISM_ADDR_TRN_STAT_0, 8'h10);
        rd_chk(`HISM_ADDR_TRN_STAT_2, 8'h00);
        rd_chk(`HISM_ADDR_TRN_STAT_1, 8'h00);
        rd_chk(`HISM_ADDR_TRN_STAT_0, 8'h00);
        settle;
        check({15'h0, irq_n}, 16'h0001);
        rd_chk(`HISM_ADDR_BLK_STAT_0, 8'h00);
        // Each channelized block in turn, rotating the requesting channel
        for (int i = 0; i < 7; i++) begin
            @(posedge sys_clk);
            chan_req <= hism_chan_t'(21'(3'b001 << (i % 3)) << (18 - 3 * i));
            settle;
            exp16 = 16'h0001 << blk_bit[i];
            rd_chk(ind_addr[i], 8'(3'b001 << (i % 3)));
            rd_chk(blk_bit[i] > 7 ? `HISM_ADDR_BLK_STAT_1 : `HISM_ADDR_BLK_STAT_0,
                   blk_bit[i] > 7 ? exp16[15:8] : exp16[7:0]);
            check({15'h0, irq_n}, 16'h0000);
            @(posedge sys_clk);
            // Host reads the source registers elsewhere, which drops the request
            chan_req <= '0;
            settle;
            rd_chk(ind_addr[i], 8'h00);
            check({15'h0, irq_n}, 16'h0001);
        end
        // Unmapped read and a write to a status register are refused
        rd_chk(16'h0200, 8'h00);
        hism_host_model_inst.write(`HISM_ADDR_OP_SRC_STAT, 8'hff);
        rd_chk(`HISM_ADDR_OP_SRC_STAT, 8'h00);
        report_and_stop;
    end
endmodule
`default_nettype wire
